// file: hdl/dsc_fifo.sv
`timescale 1ns/1ps
module dsc_fifo
	import dsc_pkg::*;
#(
	parameter int WIDTH = FIFO_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic wr_valid_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	output logic wr_ready_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in,
	output logic [WIDTH-1:0] rd_data_out
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [CW-1:0] cnt;
	} dsc_fifo_st_t;

	dsc_fifo_st_t s_r;
	dsc_fifo_st_t s_nxt;
	logic push;
	logic pop;

	// pointer advance that also works for depths other than powers of two
	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	// honest flags straight from the fill count
	assign wr_ready_out = (s_r.cnt != CW'(DEPTH));
	assign rd_valid_out = (s_r.cnt != '0);
	assign rd_data_out = s_r.mem[s_r.rp];
	assign push = wr_valid_in & wr_ready_out;
	assign pop = rd_valid_out & rd_ready_in;

	// simultaneous push and pop leave the count unchanged
	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = wr_data_in;
			s_nxt.wp = ptr_inc(s_r.wp);
		end
		if (pop) begin
			s_nxt.rp = ptr_inc(s_r.rp);
		end
		if (push && !pop) begin
			s_nxt.cnt = CW'(s_r.cnt + 1'b1);
		end else if (pop && !push) begin
			s_nxt.cnt = CW'(s_r.cnt - 1'b1);
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

// file: hdl/dsc_mode_source.sv
`timescale 1ns/1ps
// Functional notes
// - all four modes may be enabled together; fixed priority picks each parameter's source
// - precedence: programmable modulus, then ramp, then profiles, then parallel port
// - with amplitude keying active only keying drives amplitude
// - keying uses its own linear ramp that only touches amplitude
// - unmodulated parameters come from stored registers, routed per mode
// - eight profiles; in single tone the profile pins choose the parameters
// - profile pin change takes effect at next rising data clock edge
// - profile or ramp amplitude control needs keying enable bit 8 of register 0x00
// - ramp has upper, lower limits and separate rising, falling step and interval
// - ramp is 32 bits: frequency all, phase top 16, amplitude top 12
// - ramp hold pin freezes the ramp at its present value
// - ramp limit output goes high when ramp reaches upper or lower limit
// - ramp limits, steps and intervals are programmable through the register port
// - parallel word applied as unsigned binary; destination field selects its split
// - modulation drives one parameter; polar format drives phase and amplitude
// - data clock output at one sixteenth of sample rate
// - modulus mode frequency is rate times tuning word plus A over B, over 2^32
// - in modulus mode the ramp is an accumulator wrapping at B
// - each accumulator wrap adds one extra count to the phase accumulator
// - tuning word at 0x04, B at 0x05, A at 0x06, all 32 bits
// - register writes wait in holding buffers until the update pin goes high
module dsc_mode_source
	import dsc_pkg::*;
(
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic [2:0] profile_select_pins_in,
	input wire logic ramp_direction_pin_in,
	input wire logic ramp_hold_pin_in,
	input wire logic amplitude_keying_pin_in,
	input wire logic io_update_in,
	input wire logic [31:0] par_data_in,
	input wire logic reg_wr_en_in,
	input wire logic reg_rd_en_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic core_ready_in,
	output logic [31:0] reg_rdata_out,
	output logic sync_clk_out,
	output logic ramp_limit_output_out,
	output logic par_ready_out,
	output logic [31:0] freq_word_out,
	output logic [15:0] phase_word_out,
	output logic [11:0] amp_word_out,
	output logic mod_carry_out
);
	typedef struct packed {
		dsc_pins_t pin_meta;
		dsc_pins_t pin_sync;
		logic upd_prev;
		logic [3:0] div;
		logic sync_clk;
		logic [2:0] ps_act;
		logic [31:0][31:0] hold_regs;
		logic [31:0][31:0] act_regs;
		logic [31:0] rdata;
		logic [31:0] par_word;
		logic par_ready;
		logic limit;
		dsc_ctrl_t ctrl;
	} dsc_state_t;

	dsc_state_t s_r;
	dsc_state_t s_nxt;
	dsc_pins_t pins_raw;
	logic [31:0] ctrl1;
	logic [31:0] mode;
	logic [31:0] ramp_rate;
	logic [31:0] key_cfg;
	logic [11:0] key_asf;
	logic key_en;
	logic key_man;
	logic key_auto;
	logic prof_en;
	logic ramp_en;
	logic par_en;
	logic mod_en;
	logic ramp_act;
	dsc_dest_t ramp_dst;
	dsc_dest_t par_dst;
	logic [31:0] prof_freq;
	logic [31:0] prof_pa;
	logic [31:0] ramp_val;
	logic ramp_lim;
	logic ramp_wrap;
	logic [31:0] key_val;
	logic fifo_wr_valid;
	logic fifo_wr_ready;
	logic fifo_rd_valid;
	logic [31:0] fifo_rd_data;
	logic sync_tick;

	// profile storage index: two words per profile above the base
	function automatic logic [4:0] prof_idx(input logic [2:0] ps, input logic word);
		prof_idx = REG_PROF_BASE | {1'b0, ps, word};
	endfunction

	// every pin crosses two flip-flops before use
	assign pins_raw = '{data: par_data_in, ps: profile_select_pins_in, dir: ramp_direction_pin_in,
		hold: ramp_hold_pin_in, key: amplitude_keying_pin_in, update: io_update_in};

	// active register fields; the core only ever sees the active copy
	assign ctrl1 = s_r.act_regs[REG_CTRL1];
	assign mode = s_r.act_regs[REG_MODE];
	assign ramp_rate = s_r.act_regs[REG_RAMP_RATE];
	assign key_cfg = s_r.act_regs[REG_KEY];
	assign key_asf = key_cfg[KEY_ASF_LSB +: 12];
	assign key_en = ctrl1[CTRL_KEY_EN_BIT];
	assign key_man = key_en & ctrl1[CTRL_KEY_MAN_BIT];
	assign key_auto = key_en & ctrl1[CTRL_KEY_AUTO_BIT] & ~ctrl1[CTRL_KEY_MAN_BIT];
	assign prof_en = mode[MODE_PROF_BIT];
	assign ramp_en = mode[MODE_RAMP_BIT];
	assign par_en = mode[MODE_PAR_BIT];
	assign mod_en = mode[MODE_MOD_BIT];
	assign ramp_dst = dsc_dest_t'(mode[MODE_RDST_LSB +: 2]);
	assign par_dst = dsc_dest_t'(mode[MODE_PDST_LSB +: 2]);
	// the accumulator borrows the ramp, so no sweep while modulus runs
	assign ramp_act = ramp_en & ~mod_en;
	assign prof_freq = s_r.act_regs[prof_idx(s_r.ps_act, 1'b0)];
	assign prof_pa = s_r.act_regs[prof_idx(s_r.ps_act, 1'b1)];
	assign sync_tick = (s_r.div == SYNC_TICK);
	// words are offered at each data clock rise; a full buffer drops the word
	assign fifo_wr_valid = sync_tick & par_en;

	// main sweep, doubling as the modulus accumulator
	dsc_ramp u_ramp (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.run_in(ramp_act),
		.hold_in(s_r.pin_sync.hold),
		.dir_in(s_r.pin_sync.dir),
		.mod_en_in(mod_en),
		.upper_in(s_r.act_regs[REG_RAMP_UP_LIM]),
		.lower_in(s_r.act_regs[REG_RAMP_LO_LIM]),
		.step_up_in(s_r.act_regs[REG_RAMP_STEP_UP]),
		.step_dn_in(s_r.act_regs[REG_RAMP_STEP_DN]),
		.rate_up_in(ramp_rate[RATE_UP_LSB +: 16]),
		.rate_dn_in(ramp_rate[RATE_DN_LSB +: 16]),
		.mod_a_in(s_r.act_regs[REG_MOD_A]),
		.mod_b_in(s_r.act_regs[REG_MOD_B]),
		.value_out(ramp_val),
		.limit_out(ramp_lim),
		.wrap_out(ramp_wrap)
	);

	// separate keying sweep between zero and the scale factor, amplitude only
	dsc_ramp u_key_ramp (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.run_in(key_auto),
		.hold_in(1'b0),
		.dir_in(s_r.pin_sync.key),
		.mod_en_in(1'b0),
		.upper_in({key_asf, 20'h00000}),
		.lower_in(32'h00000000),
		.step_up_in({key_cfg[KEY_STEP_LSB +: 12], 20'h00000}),
		.step_dn_in({key_cfg[KEY_STEP_LSB +: 12], 20'h00000}),
		.rate_up_in({8'h00, key_cfg[KEY_RATE_LSB +: 8]}),
		.rate_dn_in({8'h00, key_cfg[KEY_RATE_LSB +: 8]}),
		.mod_a_in(32'h00000000),
		.mod_b_in(32'h00000000),
		.value_out(key_val),
		.limit_out(),
		.wrap_out()
	);

	// parallel words queue here so a stalled core loses none until all eight entries are full
	dsc_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.wr_valid_in(fifo_wr_valid),
		.wr_data_in(s_r.pin_sync.data),
		.wr_ready_out(fifo_wr_ready),
		.rd_valid_out(fifo_rd_valid),
		.rd_ready_in(core_ready_in),
		.rd_data_out(fifo_rd_data)
	);

	// synchronisers, divider, register port and parameter steering
	always_comb begin
		s_nxt = s_r;
		s_nxt.pin_meta = pins_raw;
		s_nxt.pin_sync = s_r.pin_meta;
		s_nxt.upd_prev = s_r.pin_sync.update;
		s_nxt.div = 4'(s_r.div + 1'b1);
		s_nxt.sync_clk = s_nxt.div[3];
		if (sync_tick) begin
			s_nxt.ps_act = s_r.pin_sync.ps;
		end
		if (reg_wr_en_in && (reg_addr_in[7:5] == REG_PAGE) && (reg_addr_in[4:0] != REG_STATUS)) begin
			s_nxt.hold_regs[reg_addr_in[4:0]] = reg_wdata_in;
		end
		// rising edge of update copies the whole holding set at once
		if (s_r.pin_sync.update && !s_r.upd_prev) begin
			s_nxt.act_regs = s_r.hold_regs;
		end
		if (reg_rd_en_in) begin
			if (reg_addr_in[7:5] != REG_PAGE) begin
				s_nxt.rdata = REG_RESET_VAL;
			end else if (reg_addr_in[4:0] == REG_STATUS) begin
				s_nxt.rdata = {26'h0000000, s_r.par_ready, fifo_rd_valid, s_r.limit, s_r.ps_act};
			end else begin
				s_nxt.rdata = s_r.hold_regs[reg_addr_in[4:0]];
			end
		end
		if (fifo_rd_valid && core_ready_in) begin
			s_nxt.par_word = fifo_rd_data;
		end
		s_nxt.par_ready = fifo_wr_ready;
		s_nxt.limit = ramp_lim & ramp_act;
		// frequency: modulus, ramp, profile, parallel, else single tone profile
		s_nxt.ctrl.carry = 1'b0;
		if (mod_en) begin
			s_nxt.ctrl.freq = s_r.act_regs[REG_TUNE];
			s_nxt.ctrl.carry = ramp_wrap;
		end else if (ramp_act && (ramp_dst == DST_FREQ)) begin
			s_nxt.ctrl.freq = ramp_val;
		end else if (!prof_en && par_en && (par_dst == DST_FREQ)) begin
			s_nxt.ctrl.freq = s_r.par_word;
		end else begin
			s_nxt.ctrl.freq = prof_freq;
		end
		// phase: ramp, profile, parallel (plain or polar)
		if (ramp_act && (ramp_dst == DST_PHASE)) begin
			s_nxt.ctrl.phase = ramp_val[31:16];
		end else if (!prof_en && par_en && ((par_dst == DST_PHASE) || (par_dst == DST_POLAR))) begin
			s_nxt.ctrl.phase = s_r.par_word[31:16];
		end else begin
			s_nxt.ctrl.phase = prof_pa[PROF_PHASE_LSB +: 16];
		end
		// amplitude: full scale unless enabled; manual or automatic keying then overrides every other source
		if (!key_en) begin
			s_nxt.ctrl.amp = AMP_FULL;
		end else if (key_man) begin
			s_nxt.ctrl.amp = s_r.pin_sync.key ? key_asf : AMP_ZERO;
		end else if (key_auto) begin
			s_nxt.ctrl.amp = key_val[31:20];
		end else if (ramp_act && (ramp_dst == DST_AMP)) begin
			s_nxt.ctrl.amp = ramp_val[31:20];
		end else if (!prof_en && par_en && (par_dst == DST_AMP)) begin
			s_nxt.ctrl.amp = s_r.par_word[31:20];
		end else if (!prof_en && par_en && (par_dst == DST_POLAR)) begin
			s_nxt.ctrl.amp = s_r.par_word[11:0];
		end else begin
			s_nxt.ctrl.amp = prof_pa[PROF_AMP_LSB +: 12];
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// every output straight from state flops
	assign reg_rdata_out = s_r.rdata;
	assign sync_clk_out = s_r.sync_clk;
	assign ramp_limit_output_out = s_r.limit;
	assign par_ready_out = s_r.par_ready;
	assign freq_word_out = s_r.ctrl.freq;
	assign phase_word_out = s_r.ctrl.phase;
	assign amp_word_out = s_r.ctrl.amp;
	assign mod_carry_out = s_r.ctrl.carry;
endmodule

// file: hdl/dsc_pkg.sv
package dsc_pkg;

	// register indices on the programming port
	localparam logic [4:0] REG_CTRL1 = 5'h00;
	localparam logic [4:0] REG_MODE = 5'h01;
	localparam logic [4:0] REG_STATUS = 5'h02;
	localparam logic [4:0] REG_TUNE = 5'h04;
	localparam logic [4:0] REG_MOD_B = 5'h05;
	localparam logic [4:0] REG_MOD_A = 5'h06;
	localparam logic [4:0] REG_RAMP_UP_LIM = 5'h07;
	localparam logic [4:0] REG_RAMP_LO_LIM = 5'h08;
	localparam logic [4:0] REG_RAMP_STEP_UP = 5'h09;
	localparam logic [4:0] REG_RAMP_STEP_DN = 5'h0A;
	localparam logic [4:0] REG_RAMP_RATE = 5'h0B;
	localparam logic [4:0] REG_KEY = 5'h0C;
	localparam logic [4:0] REG_PROF_BASE = 5'h10;
	localparam logic [2:0] REG_PAGE = 3'h0;

	// control_register_one fields
	localparam int CTRL_KEY_EN_BIT = 8;
	localparam int CTRL_KEY_MAN_BIT = 9;
	localparam int CTRL_KEY_AUTO_BIT = 10;

	// mode register fields
	localparam int MODE_PROF_BIT = 0;
	localparam int MODE_RAMP_BIT = 1;
	localparam int MODE_PAR_BIT = 2;
	localparam int MODE_MOD_BIT = 3;
	localparam int MODE_RDST_LSB = 4;
	localparam int MODE_PDST_LSB = 6;

	// ramp rate and keying fields
	localparam int RATE_UP_LSB = 0;
	localparam int RATE_DN_LSB = 16;
	localparam int KEY_ASF_LSB = 0;
	localparam int KEY_STEP_LSB = 12;
	localparam int KEY_RATE_LSB = 24;

	// profile word layout
	localparam int PROF_PHASE_LSB = 0;
	localparam int PROF_AMP_LSB = 16;

	// parallel data clock: sample rate over sixteen, tick one edge before its rise
	localparam int SYNC_DIV = 16;
	localparam logic [3:0] SYNC_TICK = 4'h7;

	// reset and fixed values
	localparam logic [31:0] REG_RESET_VAL = 32'h00000000;
	localparam logic [11:0] AMP_FULL = 12'hFFF;
	localparam logic [11:0] AMP_ZERO = 12'h000;

	// parallel data buffer
	localparam int FIFO_WIDTH = 32;
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [1:0] {
		DST_FREQ = 2'b00,
		DST_PHASE = 2'b01,
		DST_AMP = 2'b10,
		DST_POLAR = 2'b11
	} dsc_dest_t;

	// external pins, sampled together
	typedef struct packed {
		logic [31:0] data;
		logic [2:0] ps;
		logic dir;
		logic hold;
		logic key;
		logic update;
	} dsc_pins_t;

	// control words handed to the synthesis core
	typedef struct packed {
		logic [31:0] freq;
		logic [15:0] phase;
		logic [11:0] amp;
		logic carry;
	} dsc_ctrl_t;

endpackage

// file: hdl/dsc_ramp.sv
`timescale 1ns/1ps
module dsc_ramp
	import dsc_pkg::*;
(
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic run_in,
	input wire logic hold_in,
	input wire logic dir_in,
	input wire logic mod_en_in,
	input wire logic [31:0] upper_in,
	input wire logic [31:0] lower_in,
	input wire logic [31:0] step_up_in,
	input wire logic [31:0] step_dn_in,
	input wire logic [15:0] rate_up_in,
	input wire logic [15:0] rate_dn_in,
	input wire logic [31:0] mod_a_in,
	input wire logic [31:0] mod_b_in,
	output logic [31:0] value_out,
	output logic limit_out,
	output logic wrap_out
);
	typedef struct packed {
		logic [31:0] value;
		logic [15:0] cnt;
		logic limit;
		logic wrap;
	} dsc_ramp_st_t;

	dsc_ramp_st_t s_r;
	dsc_ramp_st_t s_nxt;
	logic [15:0] rate;
	logic [32:0] acc_sum;

	// a step past the limit lands on the limit instead of wrapping
	function automatic logic [31:0] step_up(input logic [31:0] v, input logic [31:0] st, input logic [31:0] lim);
		logic [32:0] sum;
		sum = {1'b0, v} + {1'b0, st};
		step_up = (sum >= {1'b0, lim}) ? lim : sum[31:0];
	endfunction

	function automatic logic [31:0] step_dn(input logic [31:0] v, input logic [31:0] st, input logic [31:0] lim);
		step_dn = ({1'b0, v} <= ({1'b0, lim} + {1'b0, st})) ? lim : (v - st);
	endfunction

	assign rate = dir_in ? rate_up_in : rate_dn_in;
	assign acc_sum = {1'b0, s_r.value} + {1'b0, mod_a_in};
	assign value_out = s_r.value;
	assign limit_out = s_r.limit;
	assign wrap_out = s_r.wrap;

	// modulus accumulation beats sweeping; hold freezes value and interval count
	always_comb begin
		s_nxt = s_r;
		s_nxt.wrap = 1'b0;
		if (mod_en_in) begin
			s_nxt.cnt = '0;
			s_nxt.limit = 1'b0;
			if (acc_sum >= {1'b0, mod_b_in}) begin
				s_nxt.value = 32'(acc_sum - {1'b0, mod_b_in});
				s_nxt.wrap = 1'b1;
			end else begin
				s_nxt.value = acc_sum[31:0];
			end
		end else if (!run_in) begin
			s_nxt.value = lower_in;
			s_nxt.cnt = '0;
			s_nxt.limit = 1'b0;
		end else if (!hold_in) begin
			if (s_r.cnt >= rate) begin
				s_nxt.cnt = '0;
				if (dir_in) begin
					s_nxt.value = step_up(s_r.value, step_up_in, upper_in);
				end else begin
					s_nxt.value = step_dn(s_r.value, step_dn_in, lower_in);
				end
			end else begin
				s_nxt.cnt = 16'(s_r.cnt + 1'b1);
			end
			s_nxt.limit = dir_in ? (s_nxt.value == upper_in) : (s_nxt.value == lower_in);
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

// file: sim/dsc_chk_sva.sv
`timescale 1ns/1ps
module dsc_chk
	import dsc_pkg::*;
(
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic [2:0] profile_select_pins_in,
	input wire logic ramp_hold_pin_in,
	input wire logic io_update_in,
	input wire logic core_ready_in,
	input wire logic reg_wr_en_in,
	input wire logic reg_rd_en_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic sync_clk_out,
	input wire logic ramp_limit_output_out,
	input wire logic [31:0] freq_word_out,
	input wire logic [15:0] phase_word_out,
	input wire logic [11:0] amp_word_out,
	input wire logic mod_carry_out
);
	logic [31:0] tune_r;
	logic [4:0] quiet_r;
	// tuning word shadow, plus a count of quiet held cycles; 24 covers pin sync and profile latch delay
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			tune_r <= 32'h00000000;
			quiet_r <= 5'h00;
		end else begin
			if (reg_wr_en_in && reg_addr_in == {3'h0, REG_TUNE})
				tune_r <= reg_wdata_in;
			if (!(ramp_hold_pin_in && !io_update_in && !core_ready_in && $stable(profile_select_pins_in)))
				quiet_r <= 5'h00;
			else if (quiet_r != 5'h1F)
				quiet_r <= quiet_r + 5'h01;
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	sequence s_high8; sync_clk_out [*8] ##1 !sync_clk_out; endsequence
	sequence s_low8; !sync_clk_out [*8] ##1 sync_clk_out; endsequence
	property p_sync_high; $rose(sync_clk_out) |-> s_high8; endproperty
	property p_sync_low; $fell(sync_clk_out) |-> s_low8; endproperty
	property p_reset_zero; $fell(sys_rst_in) |-> freq_word_out == 32'h0 && phase_word_out == 16'h0
		&& amp_word_out == AMP_ZERO && !mod_carry_out && !sync_clk_out && !ramp_limit_output_out; endproperty
	property p_amp_full; $fell(sys_rst_in) |-> ##3 amp_word_out == AMP_FULL; endproperty
	property p_unmapped; reg_rd_en_in && reg_addr_in[7:5] != 3'h0 |=> reg_rdata_out == 32'h0; endproperty
	property p_rd_hold; !reg_rd_en_in |=> $stable(reg_rdata_out); endproperty
	property p_tune_rd; reg_rd_en_in && reg_addr_in == {3'h0, REG_TUNE} |=> reg_rdata_out == $past(tune_r); endproperty
	property p_frozen; quiet_r >= 5'h18 |-> $stable(freq_word_out) && $stable(phase_word_out)
		&& $stable(amp_word_out); endproperty

	a_sync_high: assert property (p_sync_high) else $error("data clock high phase wrong");
	a_sync_low: assert property (p_sync_low) else $error("data clock low phase wrong");
	a_reset_zero: assert property (p_reset_zero) else $error("outputs not clear after reset");
	a_amp_full: assert property (p_amp_full) else $error("amplitude not full scale");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
	a_tune_rd: assert property (p_tune_rd) else $error("tuning word readback wrong");
	a_frozen: assert property (p_frozen) else $error("control words moved while held");
endmodule

bind dsc_mode_source dsc_chk u_chk (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
	.profile_select_pins_in(profile_select_pins_in), .ramp_hold_pin_in(ramp_hold_pin_in),
	.io_update_in(io_update_in), .core_ready_in(core_ready_in), .reg_wr_en_in(reg_wr_en_in),
	.reg_rd_en_in(reg_rd_en_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
	.reg_rdata_out(reg_rdata_out), .sync_clk_out(sync_clk_out), .ramp_limit_output_out(ramp_limit_output_out),
	.freq_word_out(freq_word_out), .phase_word_out(phase_word_out), .amp_word_out(amp_word_out),
	.mod_carry_out(mod_carry_out));

// file: sim/dsc_ctl_model.sv
`timescale 1ns/1ps
module dsc_ctl_model
	import dsc_pkg::*;
(
	input wire logic clock_in,
	input wire logic sync_clk_in,
	input wire logic [2:0] ps_want_in,
	input wire logic dir_want_in,
	input wire logic hold_want_in,
	output logic [2:0] profile_select_pins_out,
	output logic ramp_direction_pin_out,
	output logic ramp_hold_pin_out,
	output logic [31:0] par_data_out
);
	logic sync_q;
	logic [7:0] n;
	initial begin
		sync_q = 1'b0;
		n = 8'h00;
		profile_select_pins_out = 3'h0;
		ramp_direction_pin_out = 1'b0;
		ramp_hold_pin_out = 1'b0;
		par_data_out = 32'hC3A55A00;
	end
	// words and profile choice change just after a data clock rise, leaving a full period of setup
	always @(posedge clock_in) begin
		sync_q <= sync_clk_in;
		ramp_direction_pin_out <= dir_want_in;
		ramp_hold_pin_out <= hold_want_in;
		if (sync_clk_in && !sync_q) begin
			profile_select_pins_out <= ps_want_in;
			n <= n + 8'h01;
			par_data_out <= {24'hC3A55A, n};
		end
	end
endmodule

// file: sim/test_dsc_mode_source.sv
`timescale 1ns/1ps
module test_dsc_mode_source
	import dsc_pkg::*;
;
	logic clock_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [2:0] ps_want = 3'h0;
	logic dir_want = 1'b0, hold_want = 1'b0, key_pin = 1'b0, upd = 1'b0;
	logic wr_en = 1'b0, rd_en = 1'b0, core_ready = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	wire [2:0] ps;
	wire dir_pin, hold_pin;
	wire [31:0] par_data;
	logic [31:0] rdata, freq, v;
	logic [15:0] phase;
	logic [11:0] amp;
	logic sync, limit, par_ready, carry;
	logic [31:0] mod_vals [3] = '{32'h4CCCCCCC, 32'h00000005, 32'h00000004};
	logic [31:0] hi [3] = '{32'h00000150, 32'h56780000, 32'hABC00000};
	logic [31:0] lo [3] = '{32'h00000100, 32'h12340000, 32'h11100000};
	int error_cnt = 0, n_tests = 0, k, cnt;

	always #20 clock_in = ~clock_in;

	dsc_mode_source dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .profile_select_pins_in(ps),
		.ramp_direction_pin_in(dir_pin), .ramp_hold_pin_in(hold_pin), .amplitude_keying_pin_in(key_pin),
		.io_update_in(upd), .par_data_in(par_data), .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .core_ready_in(core_ready), .reg_rdata_out(rdata),
		.sync_clk_out(sync), .ramp_limit_output_out(limit), .par_ready_out(par_ready),
		.freq_word_out(freq), .phase_word_out(phase), .amp_word_out(amp), .mod_carry_out(carry));

	dsc_ctl_model u_ctl (.clock_in(clock_in), .sync_clk_in(sync), .ps_want_in(ps_want), .dir_want_in(dir_want),
		.hold_want_in(hold_want), .profile_select_pins_out(ps), .ramp_direction_pin_out(dir_pin),
		.ramp_hold_pin_out(hold_pin), .par_data_out(par_data));

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock_in);
		wr_en <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock_in);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clock_in);
		rd_en <= 1'b0;
		#1 d = rdata;
	endtask

	// settle a fixed number of edges, then look after the updates have landed
	task wait_n(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask

	task upd_regs;
		@(posedge clock_in);
		upd <= 1'b1;
		@(posedge clock_in);
		upd <= 1'b0;
		wait_n(8);
	endtask

	task results;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// main sequence: registers, modulus, ramp, keying, profiles, parallel buffer
	initial begin
		repeat (8) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		wait_n(3);
		check("amp reset", {20'h0, amp}, {20'h0, AMP_FULL});
		for (k = 0; k < 3; k++) begin
			rd({3'h0, REG_TUNE} + k[7:0], v);
			check("reset value", v, REG_RESET_VAL);
			wr({3'h0, REG_TUNE} + k[7:0], mod_vals[k]);
			rd({3'h0, REG_TUNE} + k[7:0], v);
			check("readback", v, mod_vals[k]);
		end
		wr(8'h24, 32'hFFFFFFFF);
		rd(8'h24, v);
		check("unmapped", v, 32'h0);
		$display("test registers done");

		// four carries in five cycles hold A over B exactly, so a 100-cycle window gives 80
		wr({3'h0, REG_MODE}, 32'h00000008);
		upd_regs();
		check("freq modulus", freq, mod_vals[0]);
		cnt = 0;
		repeat (100) begin
			@(posedge clock_in);
			#1 if (carry === 1'b1) cnt++;
		end
		check("carries", cnt, 32'd80);
		$display("test modulus done");

		wr({3'h0, REG_CTRL1}, 32'h00000100);
		wr({3'h0, REG_RAMP_RATE}, 32'h00000000);
		for (k = 0; k < 3; k++) begin
			wr({3'h0, REG_RAMP_UP_LIM}, hi[k]);
			wr({3'h0, REG_RAMP_LO_LIM}, lo[k]);
			wr({3'h0, REG_RAMP_STEP_UP}, (k == 0) ? 32'h00000018 : 32'h10000000);
			wr({3'h0, REG_RAMP_STEP_DN}, (k == 0) ? 32'h00000020 : 32'h10000000);
			wr({3'h0, REG_MODE}, {26'h0, k[1:0], 4'h2});
			dir_want <= 1'b1;
			upd_regs();
			wait_n(30);
			v = (k == 0) ? freq : (k == 1) ? {phase, 16'h0} : {amp, 20'h0};
			check("ramp top", v, hi[k]);
			check("limit top", {31'h0, limit}, 32'h1);
			dir_want <= 1'b0;
			wait_n(30);
			v = (k == 0) ? freq : (k == 1) ? {phase, 16'h0} : {amp, 20'h0};
			check("ramp bottom", v, lo[k]);
			check("limit bottom", {31'h0, limit}, 32'h1);
		end
		hold_want <= 1'b1;
		dir_want <= 1'b1;
		wait_n(30);
		check("held amp", {20'h0, amp}, 32'h00000111);
		hold_want <= 1'b0;
		wait_n(30);
		check("released amp", {20'h0, amp}, 32'h00000ABC);
		$display("test ramp done");

		wr({3'h0, REG_CTRL1}, 32'h00000300);
		wr({3'h0, REG_KEY}, 32'h000007A5);
		upd_regs();
		check("key low", {20'h0, amp}, 32'h0);
		@(posedge clock_in);
		key_pin <= 1'b1;
		wait_n(8);
		check("key high", {20'h0, amp}, 32'h000007A5);
		// automatic keying: step 0x100 each cycle, so about eight steps between zero and the scale factor
		wr({3'h0, REG_CTRL1}, 32'h00000500);
		wr({3'h0, REG_KEY}, 32'h001007A5);
		upd_regs();
		wait_n(20);
		check("key ramp up", {20'h0, amp}, 32'h000007A5);
		@(posedge clock_in);
		key_pin <= 1'b0;
		wait_n(20);
		check("key ramp down", {20'h0, amp}, 32'h0);
		check("key freq", freq, 32'h0);
		$display("test keying done");

		wr({3'h0, REG_CTRL1}, 32'h00000000);
		wr({3'h0, REG_MODE}, 32'h00000000);
		for (k = 0; k < 8; k++) begin
			wr({3'h0, REG_PROF_BASE} + 8'(2 * k), 32'h5A000000 + k);
			wr({3'h0, REG_PROF_BASE} + 8'(2 * k + 1), 32'h00003C00 + k);
		end
		check("before update", freq, 32'h00000000);
		upd_regs();
		for (k = 0; k < 8; k++) begin
			ps_want <= k[2:0];
			wait_n(40);
			check("profile freq", freq, 32'h5A000000 + k);
			check("profile phase", {16'h0, phase}, 32'h00003C00 + k);
		end
		check("amp full", {20'h0, amp}, {20'h0, AMP_FULL});
		$display("test profiles done");

		wr({3'h0, REG_MODE}, 32'h00000004);
		upd_regs();
		wait_n(16 * 12);
		check("buffer full", {31'h0, par_ready}, 32'h0);
		rd({3'h0, REG_STATUS}, v);
		check("status", {26'h0, v[5:4]}, 32'h1);
		@(posedge clock_in);
		core_ready <= 1'b1;
		wait_n(40);
		check("buffer drained", {31'h0, par_ready}, 32'h1);
		check("par word", {8'h0, freq[31:8]}, 32'h00C3A55A);
		// polar split: phase from the top half, amplitude from the low twelve bits
		wr({3'h0, REG_CTRL1}, 32'h00000100);
		wr({3'h0, REG_MODE}, 32'h000000C4);
		upd_regs();
		wait_n(40);
		check("polar phase", {16'h0, phase}, 32'h0000C3A5);
		check("polar amp", {28'h0, amp[11:8]}, 32'h0000000A);
		wr({3'h0, REG_MODE}, 32'h00000005);
		upd_regs();
		wait_n(40);
		check("priority", freq, 32'h5A000007);
		$display("test parallel done");
		results();
	end

	// watchdog well beyond the roughly 1250 cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clock_in);
		error_cnt++;
		$display("[FAIL] watchdog expected finish seen timeout");
		results();
	end
endmodule
